// ==== logic/cisacf_consts.svh ====
`ifndef CISACF_CONSTS_SVH
`define CISACF_CONSTS_SVH
// ****************
// register map
// ****************
`define CISACF_OFS_CTRL 4'h0
`define CISACF_OFS_STATUS 4'h4
`define CISACF_OFS_TIMER 4'h8
`define CISACF_CTRL_RST 4'h0
`define CISACF_CTRL_EN_N 0
`define CISACF_CTRL_ADAPT 1
`define CISACF_CTRL_USBHI 2
`define CISACF_CTRL_SUSP 3
// ****************
// input flag positions
// ****************
`define CISACF_F_DC_N 0
`define CISACF_F_USB_N 1
`define CISACF_F_PREQ 2
`define CISACF_F_RESTART 3
`define CISACF_F_TERM 4
`define CISACF_F_VMODE 5
`define CISACF_F_INLIM 6
`define CISACF_F_THERM 7
`define CISACF_F_TEMPOK 8
`define CISACF_F_HALF 9
`define CISACF_F_FIFTH 10
`define CISACF_NFLAGS 11
`define CISACF_SYNC_RST 11'h003
// ****************
// timing
// ****************
`define CISACF_CLK_MHZ 125
`define CISACF_SYS_RAMP_NS 50000
`define CISACF_CHG_RAMP_US 1000
`define CISACF_RAMP_STEPS 256
`define CISACF_SYS_STEP_CYC ((`CISACF_SYS_RAMP_NS * `CISACF_CLK_MHZ / 1000) / `CISACF_RAMP_STEPS)
`define CISACF_CHG_STEP_CYC ((`CISACF_CHG_RAMP_US * `CISACF_CLK_MHZ) / `CISACF_RAMP_STEPS)
`define CISACF_TICK_CYC (`CISACF_CLK_MHZ * 1000000)
`define CISACF_PREQ_MIN 33
`define CISACF_FAST_MIN 660
`define CISACF_TOPOFF_S 15
`define CISACF_PREQ_TICKS (`CISACF_PREQ_MIN * 60)
`define CISACF_FAST_TICKS (`CISACF_FAST_MIN * 60)
`endif

// ==== logic/cisacf_pkg.sv ====
package cisacf_pkg;
    typedef enum logic [1:0] {
        SRC_NONE = 2'b00,
        SRC_USB = 2'b01,
        SRC_DC = 2'b10
    } cisacf_src_e;
    typedef enum logic [2:0] {
        ST_OFF = 3'b000,
        ST_PREQ = 3'b001,
        ST_FAST = 3'b010,
        ST_TOPOFF = 3'b011,
        ST_DONE = 3'b100,
        ST_FAULT = 3'b101,
        ST_TSUSP = 3'b110
    } cisacf_state_e;
    typedef struct packed {
        logic [10:0] sync1;
        logic [10:0] sync2;
        logic [3:0] ctrl;
        logic ack;
        logic [31:0] rdata;
        cisacf_src_e src;
        cisacf_state_e state;
        cisacf_state_e ret;
        logic [7:0] sys_lvl;
        logic [7:0] chg_lvl;
        logic [4:0] sys_pre;
        logic [8:0] chg_pre;
        logic [31:0] tick_cnt;
        logic tick;
        logic half;
        logic [15:0] tmr;
    } cisacf_s;
endpackage : cisacf_pkg

// ==== logic/cisacf_top.sv ====
// Added by the designer: the register addresses and the Avalon-MM register port.
`timescale 1ns/100ps
`include "cisacf_consts.svh"
// Overview of operation
// - dc valid, adapter select high: adapter limit, charge capped, usb input off.
// - dc valid, adapter low, no suspend: dc limit 100mA or 500mA by usb limit.
// - only usb valid, no suspend: usb limit 100mA or 500mA, adapter ignored.
// - no valid source: zero charge current whatever the mode inputs.
// - suspend with adapter low: charging off, system rail off, input suspended.
// - both sources valid: power taken only from dc.
// - charge enable low runs charger, high stops it; system rail unaffected.
// - new valid source ramps system limit from zero over about 50us.
// - dc after usb: ramp system limit to zero, switch, ramp back up.
// - charge current ramps over 1ms on turn-on, prequal exit, switch, usb limit rise.
// - below prequal threshold stay in prequal at 10% current.
// - termination current in voltage mode: 15s top-off then done.
// - no top-off entry while input or thermal limiter reduces current.
// - from done, restart fast charge when battery drops 100mV.
// - charging indicator low during prequal and fast charge.
// - charging indicator released in temperature suspend.
// - fault and fault indicator after 33 min prequal or 660 min fast.
// - fault cleared only by charge enable toggle or source removal.
// - charge current reduced when input limit would pull system rail down.
// - fast timer half rate below 50%, paused below 20%, unless voltage mode.
// - temperature suspend halts charging and freezes timers, resumes from held state.
// - thermal limiting disables termination detection.
module cisacf_top #(
    parameter int TICK_CYC = `CISACF_TICK_CYC
) (
    // clock and reset
    input wire logic MCLK_IN,
    input wire logic RST_N_IN,
    // avalon-mm slave
    input wire logic [3:0] ADDRESS_IN,
    input wire logic READ_IN,
    input wire logic WRITE_IN,
    input wire logic [3:0] BYTEENABLE_IN,
    input wire logic [31:0] WRITEDATA_IN,
    output logic [31:0] READDATA_OUT,
    output logic WAITREQUEST_OUT,
    // analog condition flags
    input wire logic DC_POWER_GOOD_N_IN,
    input wire logic USB_POWER_GOOD_N_IN,
    input wire logic BAT_BELOW_PREQUAL_IN,
    input wire logic BAT_BELOW_RESTART_IN,
    input wire logic AT_TERMINATION_CURRENT_IN,
    input wire logic VOLTAGE_MODE_IN,
    input wire logic INPUT_LIMIT_ACTIVE_IN,
    input wire logic THERMAL_LIMIT_IN,
    input wire logic TEMP_OK_IN,
    input wire logic CHG_BELOW_HALF_IN,
    input wire logic CHG_BELOW_FIFTH_IN,
    // power path control
    output logic SYS_EN_OUT,
    output logic SRC_DC_OUT,
    output logic SRC_USB_OUT,
    output logic INPUT_SUSP_OUT,
    output logic [1:0] IN_LIMIT_OUT,
    output logic [1:0] CHG_CAP_OUT,
    output logic [1:0] CHG_FRAC_OUT,
    output logic [7:0] SYS_RAMP_OUT,
    output logic [7:0] CHG_RAMP_OUT,
    // open-drain status pins
    output logic CHARGING_FLAG_N_OUT,
    output logic CHARGING_FLAG_N_OE_OUT,
    output logic FAULT_FLAG_N_OUT,
    output logic FAULT_FLAG_N_OE_OUT
);
    import cisacf_pkg::*;

    cisacf_s r_reg;
    cisacf_s r_next;
    logic [10:0] f;
    logic en_n;
    logic adapt;
    logic usb_hi;
    logic susp;
    logic susp_eff;
    cisacf_src_e want;
    logic sys_step;
    logic chg_step;
    logic charging;
    logic chg_rst;
    logic term_ok;
    logic [1:0] lim;

    // ****************
    // decode helpers
    // ****************
    function automatic logic [1:0] lim_code(input cisacf_src_e s, input logic a,
                                            input logic sp, input logic hi);
        if (s == SRC_DC && a) begin
            lim_code = 2'h3;
        end else if (s == SRC_NONE || sp) begin
            lim_code = 2'h0;
        end else begin
            lim_code = hi ? 2'h2 : 2'h1;
        end
    endfunction : lim_code

    function automatic logic is_chg(input cisacf_state_e s);
        is_chg = (s == ST_PREQ) || (s == ST_FAST);
    endfunction : is_chg

    assign f = r_reg.sync2;
    assign en_n = r_reg.ctrl[`CISACF_CTRL_EN_N];
    assign adapt = r_reg.ctrl[`CISACF_CTRL_ADAPT];
    assign usb_hi = r_reg.ctrl[`CISACF_CTRL_USBHI];
    assign susp = r_reg.ctrl[`CISACF_CTRL_SUSP];
    // adapter mode overrides suspend; usb-only ignores adapter select
    assign susp_eff = susp && !(adapt && r_reg.src == SRC_DC);
    assign lim = lim_code(r_reg.src, adapt, susp_eff, usb_hi);
    assign charging = is_chg(r_reg.state) || r_reg.state == ST_TOPOFF;
    // termination only with a quiet limiter, never under thermal limit
    assign term_ok = f[`CISACF_F_TERM] && f[`CISACF_F_VMODE] && !f[`CISACF_F_INLIM]
                     && !f[`CISACF_F_THERM];
    assign sys_step = r_reg.sys_pre == 5'(`CISACF_SYS_STEP_CYC - 1);
    assign chg_step = r_reg.chg_pre == 9'(`CISACF_CHG_STEP_CYC - 1);

    always_comb begin
        want = SRC_NONE;
        if (!f[`CISACF_F_DC_N]) begin
            want = SRC_DC;
        end else if (!f[`CISACF_F_USB_N]) begin
            want = SRC_USB;
        end
    end

    always_comb begin
        r_next = r_reg;
        chg_rst = 1'b0;
        // ****************
        // input synchronisers
        // ****************
        r_next.sync1 = {CHG_BELOW_FIFTH_IN, CHG_BELOW_HALF_IN, TEMP_OK_IN, THERMAL_LIMIT_IN,
                        INPUT_LIMIT_ACTIVE_IN, VOLTAGE_MODE_IN, AT_TERMINATION_CURRENT_IN,
                        BAT_BELOW_RESTART_IN, BAT_BELOW_PREQUAL_IN, USB_POWER_GOOD_N_IN,
                        DC_POWER_GOOD_N_IN};
        r_next.sync2 = r_reg.sync1;
        // ****************
        // register bus, one wait state per access
        // ****************
        r_next.ack = (READ_IN || WRITE_IN) && !r_reg.ack;
        if (READ_IN && !r_reg.ack) begin
            unique case (ADDRESS_IN)
                `CISACF_OFS_CTRL: r_next.rdata = {28'h0, r_reg.ctrl};
                `CISACF_OFS_STATUS: r_next.rdata = {r_reg.chg_lvl, r_reg.sys_lvl, 5'h0,
                                                    r_reg.state, 6'h0, r_reg.src};
                `CISACF_OFS_TIMER: r_next.rdata = {16'h0, r_reg.tmr};
                default: r_next.rdata = 32'h0;
            endcase
        end
        if (WRITE_IN && r_reg.ack && ADDRESS_IN == `CISACF_OFS_CTRL && BYTEENABLE_IN[0]) begin
            r_next.ctrl = WRITEDATA_IN[3:0];
        end
        if (r_next.ctrl[`CISACF_CTRL_USBHI] && !usb_hi && r_reg.src != SRC_NONE
            && !(adapt && r_reg.src == SRC_DC)) begin
            chg_rst = 1'b1;
        end
        // ****************
        // prescalers
        // ****************
        r_next.sys_pre = sys_step ? 5'h0 : r_reg.sys_pre + 5'h1;
        r_next.chg_pre = chg_step ? 9'h0 : r_reg.chg_pre + 9'h1;
        r_next.tick = r_reg.tick_cnt == 32'(TICK_CYC - 1);
        r_next.tick_cnt = r_next.tick ? 32'h0 : r_reg.tick_cnt + 32'h1;
        // ****************
        // source selection and system ramp
        // ****************
        if (want == SRC_NONE) begin
            r_next.src = SRC_NONE;
            r_next.sys_lvl = 8'h0;
        end else if (r_reg.src != want) begin
            if (r_reg.src == SRC_NONE) begin
                r_next.src = want;
                r_next.sys_lvl = 8'h0;
            end else if (r_reg.sys_lvl != 8'h0) begin
                if (sys_step) begin
                    r_next.sys_lvl = r_reg.sys_lvl - 8'h1;
                end
            end else begin
                r_next.src = want;
                chg_rst = 1'b1;
            end
        end else if (susp_eff) begin
            r_next.sys_lvl = 8'h0;
        end else if (sys_step && r_reg.sys_lvl != 8'hff) begin
            r_next.sys_lvl = r_reg.sys_lvl + 8'h1;
        end
        // ****************
        // charge state machine
        // ****************
        if (r_reg.tick && r_reg.state != ST_TSUSP) begin
            r_next.half = !r_reg.half;
        end
        if (r_reg.src == SRC_NONE || en_n || (susp_eff && r_reg.state != ST_FAULT)) begin
            r_next.state = ST_OFF;
            r_next.tmr = 16'h0;
        end else if (!f[`CISACF_F_TEMPOK] && r_reg.state != ST_TSUSP
                     && r_reg.state != ST_FAULT) begin
            r_next.ret = r_reg.state;
            r_next.state = ST_TSUSP;
        end else begin
            unique case (r_reg.state)
                ST_OFF: begin
                    r_next.tmr = 16'h0;
                    r_next.state = f[`CISACF_F_PREQ] ? ST_PREQ : ST_FAST;
                end
                ST_PREQ: begin
                    if (r_reg.tmr >= 16'(`CISACF_PREQ_TICKS)) begin
                        r_next.state = ST_FAULT;
                    end else if (!f[`CISACF_F_PREQ]) begin
                        r_next.state = ST_FAST;
                        r_next.tmr = 16'h0;
                        chg_rst = 1'b1;
                    end else if (r_reg.tick) begin
                        r_next.tmr = r_reg.tmr + 16'h1;
                    end
                end
                ST_FAST: begin
                    if (r_reg.tmr >= 16'(`CISACF_FAST_TICKS)) begin
                        r_next.state = ST_FAULT;
                    end else if (term_ok) begin
                        r_next.state = ST_TOPOFF;
                        r_next.tmr = 16'h0;
                    end else if (r_reg.tick && (f[`CISACF_F_VMODE] || (!f[`CISACF_F_FIFTH]
                                 && (!f[`CISACF_F_HALF] || r_reg.half)))) begin
                        r_next.tmr = r_reg.tmr + 16'h1;
                    end
                end
                ST_TOPOFF: begin
                    if (r_reg.tmr >= 16'(`CISACF_TOPOFF_S)) begin
                        r_next.state = ST_DONE;
                    end else if (r_reg.tick) begin
                        r_next.tmr = r_reg.tmr + 16'h1;
                    end
                end
                ST_DONE: begin
                    if (f[`CISACF_F_RESTART]) begin
                        r_next.state = ST_FAST;
                        r_next.tmr = 16'h0;
                    end
                end
                ST_FAULT: r_next.state = ST_FAULT;
                ST_TSUSP: begin
                    if (f[`CISACF_F_TEMPOK]) begin
                        r_next.state = r_reg.ret;
                    end
                end
                default: r_next.state = ST_OFF;
            endcase
        end
        // ****************
        // charge ramp; backs off while the input limiter holds the rail
        // ****************
        if (!is_chg(r_next.state) && r_next.state != ST_TOPOFF || chg_rst) begin
            r_next.chg_lvl = 8'h0;
        end else if (chg_step) begin
            if (f[`CISACF_F_INLIM]) begin
                r_next.chg_lvl = (r_reg.chg_lvl == 8'h0) ? 8'h0 : r_reg.chg_lvl - 8'h1;
            end else if (r_reg.chg_lvl != 8'hff) begin
                r_next.chg_lvl = r_reg.chg_lvl + 8'h1;
            end
        end
    end

    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            r_reg <= '0;
            // idle pin levels, so no source looks valid right after reset
            r_reg.sync1 <= `CISACF_SYNC_RST;
            r_reg.sync2 <= `CISACF_SYNC_RST;
            r_reg.ctrl <= `CISACF_CTRL_RST;
            r_reg.src <= SRC_NONE;
            r_reg.state <= ST_OFF;
            r_reg.ret <= ST_OFF;
        end else begin
            r_reg <= r_next;
        end
    end

    // ****************
    // outputs
    // ****************
    assign WAITREQUEST_OUT = (READ_IN || WRITE_IN) && !r_reg.ack;
    assign READDATA_OUT = r_reg.rdata;
    assign SYS_EN_OUT = r_reg.src != SRC_NONE && !susp_eff;
    assign SRC_DC_OUT = r_reg.src == SRC_DC;
    assign SRC_USB_OUT = r_reg.src == SRC_USB;
    assign INPUT_SUSP_OUT = r_reg.src != SRC_NONE && susp_eff;
    assign IN_LIMIT_OUT = lim;
    // cap reads as the input limit code while charging, zero otherwise
    assign CHG_CAP_OUT = charging ? lim : 2'h0;
    assign CHG_FRAC_OUT = !charging ? 2'h0 : (r_reg.state == ST_PREQ) ? 2'h1 : 2'h2;
    assign SYS_RAMP_OUT = r_reg.sys_lvl;
    assign CHG_RAMP_OUT = r_reg.chg_lvl;
    assign CHARGING_FLAG_N_OUT = 1'b0;
    assign CHARGING_FLAG_N_OE_OUT = is_chg(r_reg.state);
    assign FAULT_FLAG_N_OUT = 1'b0;
    assign FAULT_FLAG_N_OE_OUT = r_reg.state == ST_FAULT;

    // ****************
    // assertions
    // ****************
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (!RST_N_IN);

    a_chg_pin: assert property (is_chg(r_reg.state) |-> CHARGING_FLAG_N_OE_OUT)
        else $error("charging flag not driven");
    a_tsusp_pin: assert property (r_reg.state == ST_TSUSP |-> !CHARGING_FLAG_N_OE_OUT)
        else $error("charging flag driven in temp suspend");
    a_fault_pin: assert property ($rose(r_reg.state == ST_FAULT) |-> FAULT_FLAG_N_OE_OUT
        && $past(r_reg.tmr) >= 16'(`CISACF_PREQ_TICKS))
        else $error("fault without timer expiry");
    a_no_src_zero: assert property (r_reg.src == SRC_NONE |-> CHG_CAP_OUT == 2'h0
        && !SYS_EN_OUT)
        else $error("charge with no source");
    a_switch_down: assert property (r_reg.src == SRC_USB && want == SRC_DC
        && r_reg.sys_lvl != 8'h0 |=> r_reg.src == SRC_USB)
        else $error("switched before ramp down");
    a_suspend_off: assert property (susp && !adapt |=> r_reg.state == ST_OFF
        || r_reg.state == ST_FAULT && $past(r_reg.state) == ST_FAULT)
        else $error("charging in suspend");
    a_enable_off: assert property (en_n |=> r_reg.state == ST_OFF)
        else $error("charger runs while disabled");
    a_topoff_len: assert property (r_reg.state == ST_TOPOFF ##1 r_reg.state == ST_DONE
        |-> $past(r_reg.tmr) == 16'(`CISACF_TOPOFF_S))
        else $error("top-off length wrong");
    a_term_block: assert property (r_reg.state == ST_FAST && f[`CISACF_F_THERM]
        |=> r_reg.state != ST_TOPOFF)
        else $error("termination under thermal limit");
    a_tsusp_freeze: assert property (r_reg.state == ST_TSUSP ##1 r_reg.state == ST_TSUSP
        |-> $stable(r_reg.tmr) && r_reg.chg_lvl == 8'h0)
        else $error("timer moved in temp suspend");
    a_prequal_frac: assert property (r_reg.state == ST_PREQ |-> CHG_FRAC_OUT == 2'h1)
        else $error("prequal fraction wrong");
    a_inlim_back: assert property (f[`CISACF_F_INLIM] |=> r_reg.chg_lvl <= $past(r_reg.chg_lvl))
        else $error("charge ramp rose under input limit");

    c_fast: cover property (r_reg.state == ST_PREQ ##1 r_reg.state == ST_FAST);
    c_done: cover property (r_reg.state == ST_TOPOFF ##1 r_reg.state == ST_DONE);
    c_swap: cover property (r_reg.src == SRC_USB ##1 r_reg.src == SRC_DC);
    c_tsusp: cover property (r_reg.state == ST_TSUSP ##1 r_reg.state == ST_FAST);
    c_fault: cover property (r_reg.state == ST_PREQ ##1 r_reg.state == ST_FAULT);
endmodule : cisacf_top

// ==== sim/cisacf_host_model.sv ====
`timescale 1ns/100ps
// ****************
// host side of the open-drain status pins
// ****************
module cisacf_host_model (
    // pins from the charger
    input wire logic chg_n_in,
    input wire logic chg_oe_in,
    input wire logic flt_n_in,
    input wire logic flt_oe_in,
    // levels seen by the host
    output logic chg_level_out,
    output logic flt_level_out
);
    // a released pin goes to the pull-up level, never keeps the last driven value
    assign chg_level_out = chg_oe_in ? chg_n_in : 1'b1;
    assign flt_level_out = flt_oe_in ? flt_n_in : 1'b1;
endmodule : cisacf_host_model

// ==== sim/tb_charger_input_select_and_charge_fsm.sv ====
`timescale 1ns/100ps
`include "cisacf_consts.svh"
// ****************
// bench macros
// ****************
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
`define WAIT_FOR(c, n) begin for (int k = 0; k < (n) && (c) !== 1'b1; k++) @(negedge MCLK_IN); \
    if ((c) !== 1'b1) begin n_errors++; $display("[ERR] wait exp 1 got 0"); give_verdict(); end end
module tb_charger_input_select_and_charge_fsm;
    // short tick keeps the prequal fault timer inside the run
    localparam int TICK = 4;
    logic MCLK_IN, RST_N_IN, READ_IN, WRITE_IN, WAITREQUEST_OUT;
    logic [3:0] ADDRESS_IN, BYTEENABLE_IN;
    logic [31:0] WRITEDATA_IN, READDATA_OUT, e_v, m_v, rv;
    logic DC_POWER_GOOD_N_IN, USB_POWER_GOOD_N_IN, BAT_BELOW_PREQUAL_IN, BAT_BELOW_RESTART_IN;
    logic AT_TERMINATION_CURRENT_IN, VOLTAGE_MODE_IN, INPUT_LIMIT_ACTIVE_IN, THERMAL_LIMIT_IN, TEMP_OK_IN;
    logic CHG_BELOW_HALF_IN, CHG_BELOW_FIFTH_IN, SYS_EN_OUT, SRC_DC_OUT, SRC_USB_OUT, INPUT_SUSP_OUT;
    logic [1:0] IN_LIMIT_OUT, CHG_CAP_OUT, CHG_FRAC_OUT;
    logic [7:0] SYS_RAMP_OUT, CHG_RAMP_OUT;
    logic CHARGING_FLAG_N_OUT, CHARGING_FLAG_N_OE_OUT, FAULT_FLAG_N_OUT, FAULT_FLAG_N_OE_OUT, chg_pin, flt_pin;
    int n_errors, checks, seed;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    // ****************
    // design and host
    // ****************
    cisacf_top #(.TICK_CYC(TICK)) u_cisacf_top (
        .MCLK_IN(MCLK_IN), .RST_N_IN(RST_N_IN), .ADDRESS_IN(ADDRESS_IN), .READ_IN(READ_IN), .WRITE_IN(WRITE_IN),
        .BYTEENABLE_IN(BYTEENABLE_IN), .WRITEDATA_IN(WRITEDATA_IN), .READDATA_OUT(READDATA_OUT),
        .WAITREQUEST_OUT(WAITREQUEST_OUT), .DC_POWER_GOOD_N_IN(DC_POWER_GOOD_N_IN),
        .USB_POWER_GOOD_N_IN(USB_POWER_GOOD_N_IN), .BAT_BELOW_PREQUAL_IN(BAT_BELOW_PREQUAL_IN),
        .BAT_BELOW_RESTART_IN(BAT_BELOW_RESTART_IN), .AT_TERMINATION_CURRENT_IN(AT_TERMINATION_CURRENT_IN),
        .VOLTAGE_MODE_IN(VOLTAGE_MODE_IN), .INPUT_LIMIT_ACTIVE_IN(INPUT_LIMIT_ACTIVE_IN),
        .THERMAL_LIMIT_IN(THERMAL_LIMIT_IN), .TEMP_OK_IN(TEMP_OK_IN), .CHG_BELOW_HALF_IN(CHG_BELOW_HALF_IN),
        .CHG_BELOW_FIFTH_IN(CHG_BELOW_FIFTH_IN), .SYS_EN_OUT(SYS_EN_OUT), .SRC_DC_OUT(SRC_DC_OUT),
        .SRC_USB_OUT(SRC_USB_OUT), .INPUT_SUSP_OUT(INPUT_SUSP_OUT), .IN_LIMIT_OUT(IN_LIMIT_OUT),
        .CHG_CAP_OUT(CHG_CAP_OUT), .CHG_FRAC_OUT(CHG_FRAC_OUT), .SYS_RAMP_OUT(SYS_RAMP_OUT),
        .CHG_RAMP_OUT(CHG_RAMP_OUT), .CHARGING_FLAG_N_OUT(CHARGING_FLAG_N_OUT),
        .CHARGING_FLAG_N_OE_OUT(CHARGING_FLAG_N_OE_OUT), .FAULT_FLAG_N_OUT(FAULT_FLAG_N_OUT),
        .FAULT_FLAG_N_OE_OUT(FAULT_FLAG_N_OE_OUT)
    );
    cisacf_host_model u_cisacf_host_model (
        .chg_n_in(CHARGING_FLAG_N_OUT), .chg_oe_in(CHARGING_FLAG_N_OE_OUT), .flt_n_in(FAULT_FLAG_N_OUT),
        .flt_oe_in(FAULT_FLAG_N_OE_OUT), .chg_level_out(chg_pin), .flt_level_out(flt_pin)
    );
    // ****************
    // clock and read-data monitor
    // ****************
    initial begin
        MCLK_IN = 1'b0;
        forever #4 MCLK_IN = ~MCLK_IN;
    end
    // read data taken at the accepting edge; the design updates only after it
    always @(posedge MCLK_IN) begin
        if (READ_IN && WAITREQUEST_OUT === 1'b0 && exp_q.size() > 0) begin
            e_v = exp_q.pop_front();
            m_v = msk_q.pop_front();
            `CHK("read data", e_v, READDATA_OUT & m_v)
        end
    end
    // ****************
    // tasks
    // ****************
    task automatic give_verdict();
        $display("n_errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict
    task automatic bus(input logic [3:0] a, input logic w, input logic [3:0] v, input logic [3:0] be);
        logic [31:0] r;
        int k;
        r = $random(seed);
        @(posedge MCLK_IN);
        ADDRESS_IN <= a;
        WRITEDATA_IN <= {r[31:4], v};
        BYTEENABLE_IN <= be;
        READ_IN <= ~w;
        WRITE_IN <= w;
        k = 0;
        do begin
            @(posedge MCLK_IN);
            k++;
        end while (WAITREQUEST_OUT !== 1'b0 && k < 50);
        if (WAITREQUEST_OUT !== 1'b0) begin
            n_errors++;
            $display("[ERR] waitrequest exp 0 got 1");
            give_verdict();
        end
        READ_IN <= 1'b0;
        WRITE_IN <= 1'b0;
    endtask : bus
    task automatic wr(input logic [3:0] a, input logic [3:0] v);
        logic [31:0] r;
        r = $random(seed);
        bus(a, 1'b1, v, {r[3:1], 1'b1});
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        bus(a, 1'b0, 4'h0, 4'hf);
    endtask : rd
    // ****************
    // main sequence
    // ****************
    initial begin
        seed = 25;
        n_errors = 0;
        checks = 0;
        {RST_N_IN, READ_IN, WRITE_IN, ADDRESS_IN, BYTEENABLE_IN, WRITEDATA_IN} = '0;
        {DC_POWER_GOOD_N_IN, USB_POWER_GOOD_N_IN, TEMP_OK_IN} = 3'h7;
        {BAT_BELOW_PREQUAL_IN, BAT_BELOW_RESTART_IN, AT_TERMINATION_CURRENT_IN, VOLTAGE_MODE_IN} = 4'h0;
        {INPUT_LIMIT_ACTIVE_IN, THERMAL_LIMIT_IN, CHG_BELOW_HALF_IN, CHG_BELOW_FIFTH_IN} = 4'h0;
        repeat (5) @(posedge MCLK_IN);
        RST_N_IN <= 1'b1;
        rd(`CISACF_OFS_CTRL, 32'h0, 32'hffffffff);
        rd(`CISACF_OFS_STATUS, 32'h0, 32'hffffffff);
        wr(4'hc, 4'hf);
        bus(`CISACF_OFS_CTRL, 1'b1, 4'hf, 4'he);
        rd(4'hc, 32'h0, 32'hffffffff);
        rd(`CISACF_OFS_CTRL, 32'h0, 32'hffffffff);
        repeat (5) @(negedge MCLK_IN);
        `CHK("frac no source", 2'd0, CHG_FRAC_OUT)
        `CHK("charging pin idle", 1'b1, chg_pin)
        // usb only, then usb limit raised with adapter select ignored
        @(posedge MCLK_IN);
        USB_POWER_GOOD_N_IN <= 1'b0;
        `WAIT_FOR(SRC_USB_OUT, 20)
        `CHK("sys ramp start", 1'b1, SYS_RAMP_OUT < 8'h10)
        `WAIT_FOR(CHG_FRAC_OUT == 2'd2, 20)
        `CHK("charging pin fast", 1'b0, chg_pin)
        `CHK("usb limit low", 2'd1, IN_LIMIT_OUT)
        `CHK("chg ramp start", 1'b1, CHG_RAMP_OUT < 8'h08)
        `WAIT_FOR(SYS_RAMP_OUT == 8'hff, 8000)
        `CHK("chg ramp slow", 1'b1, CHG_RAMP_OUT > 8'h00 && CHG_RAMP_OUT < 8'hff)
        wr(`CISACF_OFS_CTRL, 4'h6);
        repeat (4) @(negedge MCLK_IN);
        `CHK("usb limit high", 2'd2, IN_LIMIT_OUT)
        // dc arrives after usb
        @(posedge MCLK_IN);
        DC_POWER_GOOD_N_IN <= 1'b0;
        `WAIT_FOR(SRC_DC_OUT, 8000)
        `CHK("sys ramp down", 1'b1, SYS_RAMP_OUT < 8'h10)
        `CHK("usb off", 1'b0, SRC_USB_OUT)
        `CHK("chg ramp switch", 1'b1, CHG_RAMP_OUT < 8'h08)
        `CHK("adapter limit", 2'd3, IN_LIMIT_OUT)
        `CHK("adapter cap", 2'd3, CHG_CAP_OUT)
        wr(`CISACF_OFS_CTRL, 4'h4);
        repeat (4) @(negedge MCLK_IN);
        `CHK("dc 500", 2'd2, IN_LIMIT_OUT)
        wr(`CISACF_OFS_CTRL, 4'h0);
        repeat (4) @(negedge MCLK_IN);
        `CHK("dc 100", 2'd1, IN_LIMIT_OUT)
        // suspend, then suspend with adapter select
        wr(`CISACF_OFS_CTRL, 4'h8);
        repeat (4) @(negedge MCLK_IN);
        `CHK("susp sys", 1'b0, SYS_EN_OUT)
        `CHK("susp input", 1'b1, INPUT_SUSP_OUT)
        `CHK("susp frac", 2'd0, CHG_FRAC_OUT)
        wr(`CISACF_OFS_CTRL, 4'ha);
        repeat (4) @(negedge MCLK_IN);
        `CHK("adapter susp", 1'b0, INPUT_SUSP_OUT)
        // prequal timeout, fault held until charge enable toggles
        @(posedge MCLK_IN);
        BAT_BELOW_PREQUAL_IN <= 1'b1;
        wr(`CISACF_OFS_CTRL, 4'h1);
        wr(`CISACF_OFS_CTRL, 4'h0);
        `WAIT_FOR(CHG_FRAC_OUT == 2'd1, 20)
        `CHK("charging pin preq", 1'b0, chg_pin)
        `WAIT_FOR(FAULT_FLAG_N_OE_OUT, 8500)
        `CHK("fault pin", 1'b0, flt_pin)
        rd(`CISACF_OFS_STATUS, 32'h500, 32'h700);
        rd(`CISACF_OFS_TIMER, `CISACF_PREQ_TICKS, 32'hffffffff);
        @(posedge MCLK_IN);
        BAT_BELOW_PREQUAL_IN <= 1'b0;
        repeat (10) @(negedge MCLK_IN);
        `CHK("fault held", 1'b0, flt_pin)
        wr(`CISACF_OFS_CTRL, 4'h1);
        wr(`CISACF_OFS_CTRL, 4'h0);
        `WAIT_FOR(CHG_FRAC_OUT == 2'd2, 20)
        `CHK("fault cleared", 1'b1, flt_pin)
        // temperature suspend and resume
        @(posedge MCLK_IN);
        TEMP_OK_IN <= 1'b0;
        repeat (5) @(negedge MCLK_IN);
        `CHK("tsusp pin", 1'b1, chg_pin)
        rd(`CISACF_OFS_STATUS, 32'h600, 32'h700);
        @(posedge MCLK_IN);
        TEMP_OK_IN <= 1'b1;
        `WAIT_FOR(CHG_FRAC_OUT == 2'd2, 20)
        `CHK("tsusp resume", 1'b0, chg_pin)
        // termination blocked by limiters, then top-off, done and restart
        rv = $random(seed);
        @(posedge MCLK_IN);
        {CHG_BELOW_HALF_IN, CHG_BELOW_FIFTH_IN} <= rv[1:0];
        {VOLTAGE_MODE_IN, AT_TERMINATION_CURRENT_IN, THERMAL_LIMIT_IN} <= 3'h7;
        repeat (100) @(negedge MCLK_IN);
        `CHK("thermal no term", 2'd2, CHG_FRAC_OUT)
        @(posedge MCLK_IN);
        {THERMAL_LIMIT_IN, INPUT_LIMIT_ACTIVE_IN} <= 2'h1;
        repeat (100) @(negedge MCLK_IN);
        rd(`CISACF_OFS_STATUS, 32'h200, 32'h700);
        @(posedge MCLK_IN);
        INPUT_LIMIT_ACTIVE_IN <= 1'b0;
        repeat (8) @(negedge MCLK_IN);
        rd(`CISACF_OFS_STATUS, 32'h300, 32'h700);
        `WAIT_FOR(CHG_FRAC_OUT == 2'd0, 200)
        rd(`CISACF_OFS_STATUS, 32'h400, 32'h700);
        @(posedge MCLK_IN);
        {AT_TERMINATION_CURRENT_IN, BAT_BELOW_RESTART_IN} <= 2'h1;
        `WAIT_FOR(CHG_FRAC_OUT == 2'd2, 50)
        `CHK("restart pin", 1'b0, chg_pin)
        // charger off leaves the system rail alone
        wr(`CISACF_OFS_CTRL, 4'h1);
        repeat (4) @(negedge MCLK_IN);
        `CHK("disabled frac", 2'd0, CHG_FRAC_OUT)
        `CHK("disabled sys", 1'b1, SYS_EN_OUT)
        give_verdict();
    end
endmodule : tb_charger_input_select_and_charge_fsm
